// >>> lbk_ctrl.v
`timescale 1ns/1ns
`include "lbk_consts.vh"

// Function
// - Three independent channels 0..2, each with own loop select and transmit disable.
// - Analog local loop ignores line input; line output feeds the receive path.
// - Host mode: local bit D1 one, remote bit D0 zero gives analog loop.
// - Hardware mode: local pin high, remote pin low gives analog loop.
// - Digital local loop ignores line input; encoded transmit data goes to decoder.
// - Host mode: local and remote bits both one give digital loop.
// - Hardware mode: local and remote pins both high give digital loop.
// - Remote loop ignores transmit data; received line data is retransmitted unless host-mode bit D3 of transmit control forces all ones.
// - Host mode: remote bit one, local bit zero gives remote loop.
// - Hardware mode: remote pin high, local pin low gives remote loop.
// - A shut-off transmitter puts its line outputs in high impedance.
// - Shared transmit disable pin high shuts off all channel drivers.
// - Host mode: bit D4 of transmit control disables that channel driver.
// - Driver active only with pin low and channel disable bit zero.
// - Serial interface pins serve all channels in host mode, unused otherwise.
// - All command fields reset to zero: normal operation, transmitter enabled.
module lbk_ctrl #(
  parameter NCH        = `LBK_NUM_CH,
  parameter FIFO_DEPTH = `LBK_FIFO_DEPTH
) (
  input  wire           mclk,
  input  wire           arst_n,
  input  wire           host_mode,
  input  wire           transmit_disable,
  input  wire [NCH-1:0] local_loop_select,
  input  wire [NCH-1:0] remote_loop_select,
  input  wire [NCH-1:0] tx_terminal_clock,
  input  wire [NCH-1:0] tx_positive_rail_in,
  input  wire [NCH-1:0] tx_negative_rail_in,
  input  wire [NCH-1:0] rx_line_clock,
  input  wire [NCH-1:0] rx_line_positive,
  input  wire [NCH-1:0] rx_line_negative,
  output wire [NCH-1:0] tx_line_positive,
  output wire [NCH-1:0] tx_line_negative,
  output wire [NCH-1:0] tx_line_oe,
  output wire [NCH-1:0] rx_positive_rail_out,
  output wire [NCH-1:0] rx_negative_rail_out,
  output wire [NCH-1:0] recovered_clock_out,
  output wire [NCH-1:0] tx_accept_ready,
  input  wire           serial_clock,
  input  wire           serial_data_in,
  input  wire           serial_select_n,
  output wire           serial_data_out,
  output wire           serial_data_out_oe
);

  // Two shared pins, eight per-channel groups, three serial pins
  localparam AW  = 8 * NCH + 5;
  // Both command registers share one width
  localparam RW  = `LBK_REG_W;

  // Async input bundle, all through two flops before use
  wire [AW-1:0] async_in;
  reg  [AW-1:0] sync1_reg;
  reg  [AW-1:0] sync2_reg;
  reg  [NCH-1:0] txc_prev_reg;
  reg  [NCH-1:0] rxc_prev_reg;
  reg            sclk_prev_reg;

  assign async_in = {host_mode, transmit_disable, local_loop_select, remote_loop_select,
                     tx_terminal_clock, tx_positive_rail_in, tx_negative_rail_in,
                     rx_line_clock, rx_line_positive, rx_line_negative,
                     serial_clock, serial_data_in, serial_select_n};

  // Select resets to its idle high level so no frame looks open early
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= {{(AW-1){1'b0}}, 1'b1};
      sync2_reg <= {{(AW-1){1'b0}}, 1'b1};
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Unpack the settled copies
  wire           host_s  = sync2_reg[AW-1];
  wire           txdis_s = sync2_reg[AW-2];
  wire [NCH-1:0] llb_s   = sync2_reg[AW-3 -: NCH];
  wire [NCH-1:0] rlb_s   = sync2_reg[AW-3-NCH -: NCH];
  wire [NCH-1:0] txc_s   = sync2_reg[AW-3-2*NCH -: NCH];
  wire [NCH-1:0] txp_s   = sync2_reg[AW-3-3*NCH -: NCH];
  wire [NCH-1:0] txn_s   = sync2_reg[AW-3-4*NCH -: NCH];
  wire [NCH-1:0] rxc_s   = sync2_reg[AW-3-5*NCH -: NCH];
  wire [NCH-1:0] rxp_s   = sync2_reg[AW-3-6*NCH -: NCH];
  wire [NCH-1:0] rxn_s   = sync2_reg[AW-3-7*NCH -: NCH];
  wire           sclk_s  = sync2_reg[2];
  wire           sdi_s   = sync2_reg[1];
  wire           csn_s   = sync2_reg[0];

  // Previous clock levels for edge detection
  // Link clocks are only sampled, so the block stays in one clock domain
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txc_prev_reg  <= {NCH{1'b0}};
      rxc_prev_reg  <= {NCH{1'b0}};
      sclk_prev_reg <= 1'b0;
    end else begin
      txc_prev_reg  <= txc_s;
      rxc_prev_reg  <= rxc_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  // Command registers, one pair per channel
  // The loop register top bit is reserved and masked on write and read
  reg [RW-1:0] txctl_reg [0:NCH-1];
  reg [RW-1:0] lbcfg_reg [0:NCH-1];

  // Serial frame state
  reg [3:0]    bit_cnt_reg;
  reg          rd_flag_reg;
  reg [4:0]    addr_reg;
  reg [3:0]    wdata_reg;
  reg [RW-1:0] rd_shift_reg;
  reg          sdo_reg;
  wire         sclk_rise = sclk_s & ~sclk_prev_reg;
  wire [4:0]   addr_next = {addr_reg[3:0], sdi_s};
  wire [RW-1:0] wdata_full = {wdata_reg, sdi_s};
  integer      k;

  // Read decode; unmapped addresses and reserved bits read zero
  // Channel field value three selects nothing
  function [RW-1:0] reg_read;
    input [4:0] a;
    begin
      reg_read = {RW{1'b0}};
      if ({3'h0, a[4:3]} < NCH) begin
        if (a[2:0] == `LBK_IDX_TXCTL) begin
          reg_read = txctl_reg[a[4:3]];
        end else if (a[2:0] == `LBK_IDX_LBCFG) begin
          reg_read = lbcfg_reg[a[4:3]] & `LBK_LBCFG_MASK;
        end
      end
    end
  endfunction

  // Serial shifter; frames are ignored outside host mode
  // A released select or a switch to pin mode restarts the frame
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg  <= 4'h0;
      rd_flag_reg  <= 1'b0;
      addr_reg     <= 5'h00;
      wdata_reg    <= 4'h0;
      rd_shift_reg <= {RW{1'b0}};
      sdo_reg      <= 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        txctl_reg[k] <= `LBK_REG_RESET;
        lbcfg_reg[k] <= `LBK_REG_RESET;
      end
    end else if (csn_s || !host_s) begin
      bit_cnt_reg <= 4'h0;
      sdo_reg     <= 1'b0;
    end else if (sclk_rise && bit_cnt_reg != `LBK_FRAME_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == `LBK_BIT_RDFLAG) begin
        rd_flag_reg <= sdi_s;
      end else if (bit_cnt_reg <= `LBK_BIT_ADDR_LAST) begin
        addr_reg <= addr_next;
        if (bit_cnt_reg == `LBK_BIT_ADDR_LAST) begin
          // Read data is latched here so later writes cannot tear it
          {sdo_reg, rd_shift_reg} <= {reg_read(addr_next), 1'b0};
        end
      end else begin
        wdata_reg    <= wdata_full[3:0];
        sdo_reg      <= rd_shift_reg[RW-1];
        rd_shift_reg <= rd_shift_reg << 1;
        if (bit_cnt_reg == `LBK_BIT_DATA_LAST && !rd_flag_reg) begin
          for (k = 0; k < NCH; k = k + 1) begin
            if (addr_reg[4:3] == k[1:0] && addr_reg[2:0] == `LBK_IDX_TXCTL) begin
              txctl_reg[k] <= wdata_full;
            end
            if (addr_reg[4:3] == k[1:0] && addr_reg[2:0] == `LBK_IDX_LBCFG) begin
              lbcfg_reg[k] <= wdata_full & `LBK_LBCFG_MASK;
            end
          end
        end
      end
    end
  end

  // Output drive only during the data phase of a read
  // Released two cycles after select rises, so the host may drive next
  assign serial_data_out    = sdo_reg;
  assign serial_data_out_oe = ~csn_s & host_s & rd_flag_reg &
                              (bit_cnt_reg > `LBK_BIT_ADDR_LAST);

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [RW-1:0] txctl = txctl_reg[g];
      wire [RW-1:0] lbcfg = lbcfg_reg[g];
      wire llb = host_s ? lbcfg[`LBK_LBCFG_LOCAL]  : llb_s[g];
      wire rlb = host_s ? lbcfg[`LBK_LBCFG_REMOTE] : rlb_s[g];
      wire ana = llb & ~rlb;
      wire dig = llb & rlb;
      wire rem = rlb & ~llb;
      wire inv = host_s & txctl[`LBK_TXCTL_CLKINV];
      wire aos = host_s & txctl[`LBK_TXCTL_AOS];
      // Pin and bit combine by OR into the shut-off
      // The pin path is short for quick fail-over; a bit needs a whole frame
      wire drv_en = ~txdis_s & ~txctl[`LBK_TXCTL_TRANSMIT_DISABLE];
      wire tx_edge = inv ? (txc_prev_reg[g] & ~txc_s[g]) : (~txc_prev_reg[g] & txc_s[g]);
      wire rx_edge = ~rxc_prev_reg[g] & rxc_s[g];
      // Remote loop is paced by line timing, everything else by terminal timing
      wire line_edge = rem ? rx_edge : tx_edge;
      reg  mark_reg;
      reg  [1:0] line_reg;
      reg  [1:0] rx_reg;
      reg  rclk_reg;
      wire [1:0] src;
      wire [1:0] fifo_dout;
      wire fifo_valid;

      // All-ones alternates marks; remote loop drops terminal data
      assign src = aos ? {mark_reg, ~mark_reg} :
                   rem ? {rxp_s[g], rxn_s[g]} : {txp_s[g], txn_s[g]};

      // Drain stalls while the driver is off, so the buffer fills
      // Limitation: a filled buffer stays nearly full afterwards, so the
      // transmit delay grows to one entry less than the depth until the next reset
      lbk_fifo #(
        .WIDTH (`LBK_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (`LBK_FIFO_AW)
      ) u_fifo (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .in_valid  (line_edge),
        .in_ready  (tx_accept_ready[g]),
        .in_data   (src),
        .out_valid (fifo_valid),
        .out_ready (line_edge & drv_en),
        .out_data  (fifo_dout)
      );

      // All-ones phase flips on every pacing edge
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          mark_reg <= 1'b0;
        end else if (line_edge) begin
          mark_reg <= ~mark_reg;
        end
      end

      // Line driver register; cleared at once on shut-off so no stale mark lingers
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          line_reg <= 2'h0;
        end else if (!drv_en) begin
          line_reg <= 2'h0;
        end else if (line_edge) begin
          line_reg <= fifo_valid ? fifo_dout : 2'h0;
        end
      end

      assign tx_line_positive[g] = line_reg[1];
      assign tx_line_negative[g] = line_reg[0];
      assign tx_line_oe[g]       = drv_en;

      // Clock copy follows the side that the receive rails come from
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          rclk_reg <= 1'b0;
        end else begin
          rclk_reg <= (ana | dig) ? txc_s[g] : rxc_s[g];
        end
      end

      // Receive rail source per mode; local loops take the transmit side
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          rx_reg   <= 2'h0;
        end else begin
          if (ana) begin
            // Only what the driver really puts on the line comes back
            if (tx_edge) begin
              rx_reg <= drv_en ? line_reg : 2'h0;
            end
          end else if (dig) begin
            // Taken before the driver, but a shut-off stalls the buffer, so the head entry repeats here
            if (tx_edge) begin
              rx_reg <= fifo_valid ? fifo_dout : 2'h0;
            end
          end else if (rx_edge) begin
            rx_reg <= {rxp_s[g], rxn_s[g]};
          end
        end
      end

      assign rx_positive_rail_out[g] = rx_reg[1];
      assign rx_negative_rail_out[g] = rx_reg[0];
      assign recovered_clock_out[g]  = rclk_reg;
    end
  endgenerate

endmodule // lbk_ctrl

// >>> lbk_consts.vh
`ifndef LBK_CONSTS_VH
`define LBK_CONSTS_VH

// Channel count and register address layout
`define LBK_NUM_CH        3
`define LBK_ADDR_W        5
`define LBK_REG_W         5
`define LBK_IDX_TXCTL     3'h1
`define LBK_IDX_LBCFG     3'h4

// Transmit control field positions
`define LBK_TXCTL_TRANSMIT_DISABLE   4
`define LBK_TXCTL_AOS     3
`define LBK_TXCTL_CLKINV  2

// Loopback field positions
`define LBK_LBCFG_LOCAL   1
`define LBK_LBCFG_REMOTE  0
`define LBK_LBCFG_MASK    5'h0f

// Reset value of every command field
`define LBK_REG_RESET     5'h00

// Serial frame layout: read flag, five address bits, five data bits
`define LBK_BIT_RDFLAG    4'h0
`define LBK_BIT_ADDR_LAST 4'h5
`define LBK_BIT_DATA_LAST 4'ha
`define LBK_FRAME_BITS    4'hb

// Transmit buffer shape
`define LBK_FIFO_WIDTH    2
`define LBK_FIFO_DEPTH    16
`define LBK_FIFO_AW       4

`endif

// >>> lbk_fifo.v
`timescale 1ns/1ns
module lbk_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             arst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;
  integer         i;

  // Full and empty come straight from the occupancy count
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap explicitly so DEPTH need not be a power of two
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // lbk_fifo

// >>> lbk_checker.sv
`timescale 1ns/1ns
module lbk_checker #(parameter NCH = 3) (
  input wire           mclk,
  input wire           arst_n,
  input wire           host_mode,
  input wire           transmit_disable,
  input wire [NCH-1:0] local_loop_select,
  input wire [NCH-1:0] tx_terminal_clock,
  input wire [NCH-1:0] rx_line_clock,
  input wire [NCH-1:0] tx_line_positive,
  input wire [NCH-1:0] tx_line_negative,
  input wire [NCH-1:0] tx_line_oe,
  input wire [NCH-1:0] rx_positive_rail_out,
  input wire [NCH-1:0] recovered_clock_out,
  input wire [NCH-1:0] tx_accept_ready,
  input wire           serial_select_n,
  input wire           serial_data_out_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Pin levels held long enough to cross the synchronisers
  sequence s_hw_on;
    (!host_mode && !transmit_disable)[*4];
  endsequence
  sequence s_loc;
    (!host_mode && local_loop_select[0])[*8];
  endsequence
  sequence s_rem;
    (!host_mode && !local_loop_select[0])[*8];
  endsequence
  a_pin_shuts_all: assert property (transmit_disable[*4] |-> tx_line_oe == '0)
    else $error("driver on while shared disable pin high");
  a_hw_driver_on: assert property (s_hw_on |-> tx_line_oe == '1)
    else $error("driver off with pin low in pin mode");
  a_off_line_quiet: assert property ((!tx_line_oe[0])[*3] |->
    !(tx_line_positive[0] | tx_line_negative[0]))
    else $error("line data while driver off");
  a_reset_values: assert property ($rose(arst_n) |-> tx_accept_ready == '1
    && rx_positive_rail_out == '0 && !serial_data_out_oe)
    else $error("outputs not at reset values");
  a_sdo_idle: assert property (serial_select_n[*5] |-> !serial_data_out_oe)
    else $error("serial output driven while deselected");
  a_hw_no_read: assert property ((!host_mode)[*4] |-> !serial_data_out_oe)
    else $error("serial output driven in pin mode");
  // Clock copy must follow the terminal clock in local loops, the line clock otherwise
  a_local_clock: assert property (s_loc ##0 $rose(recovered_clock_out[0]) |->
    $past(tx_terminal_clock[0], 1) && !$past(tx_terminal_clock[0], 4))
    else $error("local loop clock not from terminal clock");
  a_line_clock: assert property (s_rem ##0 $rose(recovered_clock_out[0]) |->
    $past(rx_line_clock[0], 1) && !$past(rx_line_clock[0], 4))
    else $error("line clock not selected");
endmodule // lbk_checker

bind lbk_ctrl lbk_checker #(.NCH(NCH)) u_chk (.*);

// >>> lbk_partner.sv
`timescale 1ns/1ns
module lbk_partner (
  output logic [2:0] tx_terminal_clock,
  output logic [2:0] rx_line_clock,
  output logic [2:0] tx_positive_rail_in,
  output logic [2:0] tx_negative_rail_in,
  output logic [2:0] rx_line_positive,
  output logic [2:0] rx_line_negative,
  input  wire  [1:0] tx_word,
  input  wire  [1:0] rx_word
);
  // Free-running clocks half a period apart so a wrong clock choice shows
  initial begin
    {tx_terminal_clock, rx_line_clock} = '0;
    {tx_positive_rail_in, tx_negative_rail_in, rx_line_positive, rx_line_negative} = '0;
    #7;
    fork
      forever #80 tx_terminal_clock = ~tx_terminal_clock;
      #80 forever #80 rx_line_clock = ~rx_line_clock;
    join
  end
  // Rails move on the falling edge so they are steady at the rising one
  always @(negedge tx_terminal_clock[0])
    {tx_positive_rail_in, tx_negative_rail_in} <= {{3{tx_word[1]}}, {3{tx_word[0]}}};
  always @(negedge rx_line_clock[0])
    {rx_line_positive, rx_line_negative} <= {{3{rx_word[1]}}, {3{rx_word[0]}}};
endmodule // lbk_partner

// >>> tb_lbk_ctrl.sv
`timescale 1ns/1ns
`include "lbk_consts.vh"
module tb_lbk_ctrl;
  logic       mclk = 0, arst_n = 0, host_mode = 1;
  logic       transmit_disable = 0;
  logic [2:0] local_loop_select = 0, remote_loop_select = 0;
  logic       serial_clock = 0, serial_data_in = 0, serial_select_n = 1;
  logic [1:0] tx_word = 2'h1, rx_word = 2'h2;
  wire  [2:0] tx_terminal_clock, rx_line_clock, tx_positive_rail_in, tx_negative_rail_in;
  wire  [2:0] rx_line_positive, rx_line_negative, tx_line_positive, tx_line_negative;
  wire  [2:0] tx_line_oe, rx_positive_rail_out, rx_negative_rail_out, recovered_clock_out;
  wire  [2:0] tx_accept_ready;
  wire        serial_data_out, serial_data_out_oe;
  int         num_errors = 0, samples_checked = 0;
  logic [4:0] q;
  logic [4:0] rv [3];
  logic [1:0] mc [3];

  lbk_ctrl dut (.*);
  lbk_partner u_far (.*);

  initial forever #10 mclk = ~mclk;

  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One frame: read flag, address, data; slow clock keeps the synchroniser happy
  task automatic ser(input logic rd, input logic [4:0] a, input logic [4:0] d);
    logic [10:0] f;
    f = {rd, a, d};
    serial_select_n = 0;
    for (int i = 10; i >= 0; i--) begin
      serial_data_in = f[i];
      repeat (5) @(negedge mclk);
      if (i < 5) q[i] = serial_data_out;
      serial_clock = 1;
      repeat (5) @(negedge mclk);
      serial_clock = 0;
    end
    repeat (5) @(negedge mclk);
    serial_select_n = 1;
    repeat (5) @(negedge mclk);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [4:0] e);
    ser(1, a, 5'h00);
    chk(q, e);
  endtask

  // Receive rails carry transmit data only in the two local loops
  function automatic logic [1:0] exp_rx(input logic [1:0] m);
    return m[1] ? tx_word : rx_word;
  endfunction
  function automatic logic [1:0] exp_ln(input logic [1:0] m);
    return (m == 2'h1) ? rx_word : tx_word;
  endfunction

  task automatic end_sim;
    $display("Checked %0d samples, %0d errors", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: the sequence needs well under a millisecond
  initial begin
    #1000000;
    num_errors++;
    end_sim;
  end

  initial begin
    void'($urandom(32'h166a));
    repeat (8) @(negedge mclk);
    arst_n = 1;
    repeat (5) @(negedge mclk);
    // Defaults, then independent per-channel contents
    for (int c = 0; c < 3; c++) begin
      rchk({c[1:0], `LBK_IDX_TXCTL}, `LBK_REG_RESET);
      rchk({c[1:0], `LBK_IDX_LBCFG}, `LBK_REG_RESET);
    end
    chk({2'h0, tx_line_oe}, 5'h07);
    for (int c = 0; c < 3; c++) begin
      rv[c] = 5'($urandom);
      ser(0, {c[1:0], `LBK_IDX_TXCTL}, rv[c]);
      ser(0, {c[1:0], `LBK_IDX_LBCFG}, ~rv[c]);
    end
    for (int c = 0; c < 3; c++) begin
      rchk({c[1:0], `LBK_IDX_TXCTL}, rv[c]);
      rchk({c[1:0], `LBK_IDX_LBCFG}, ~rv[c] & `LBK_LBCFG_MASK);
      ser(0, {c[1:0], `LBK_IDX_TXCTL}, 5'h00);
      ser(0, {c[1:0], `LBK_IDX_LBCFG}, 5'h00);
    end
    ser(0, 5'h19, 5'h1f);
    rchk(5'h19, 5'h00);
    rchk(5'h02, 5'h00);
    // Shared pin ORed with the channel 1 bit; other channels see the pin only
    for (int k = 0; k < 4; k++) begin
      ser(0, {2'h1, `LBK_IDX_TXCTL}, {k[1], 4'h0});
      transmit_disable = k[0];
      repeat (6) @(negedge mclk);
      chk({2'h0, tx_line_oe}, {2'h0, ~k[0], ~(k[0] | k[1]), ~k[0]});
    end
    transmit_disable = 0;
    ser(0, {2'h1, `LBK_IDX_TXCTL}, 5'h00);
    // Driver off stops draining, so the buffer fills and refuses
    ser(0, 5'h01, 5'h10);
    repeat (300) @(negedge mclk);
    chk({4'h0, tx_accept_ready[0]}, 5'h00);
    chk({3'h0, tx_line_positive[0], tx_line_negative[0]}, 5'h00);
    ser(0, 5'h01, 5'h00);
    // Every loop mode on every channel, by pins then by registers
    for (int hm = 0; hm < 2; hm++) begin
      host_mode = hm[0];
      for (int m = 0; m < 4; m++) begin
        tx_word = 2'($urandom % 2 + 1);
        rx_word = ~tx_word;
        for (int c = 0; c < 3; c++) begin
          mc[c] = 2'(m + c);
          {local_loop_select[c], remote_loop_select[c]} = hm[0] ? 2'($urandom) : mc[c];
          if (hm[0]) ser(0, {c[1:0], `LBK_IDX_LBCFG}, {3'h0, mc[c]});
        end
        // Long enough for a buffer refilled by a shut-off to flush through
        repeat (200) @(negedge mclk);
        for (int c = 0; c < 3; c++) begin
          chk({3'h0, rx_positive_rail_out[c], rx_negative_rail_out[c]},
              {3'h0, exp_rx(mc[c])});
          chk({3'h0, tx_line_positive[c], tx_line_negative[c]},
              {3'h0, exp_ln(mc[c])});
        end
      end
    end
    // Pin mode ignores the serial port
    host_mode = 0;
    repeat (5) @(negedge mclk);
    ser(0, 5'h04, 5'h00);
    ser(1, 5'h04, 5'h00);
    host_mode = 1;
    repeat (5) @(negedge mclk);
    rchk(5'h04, {3'h0, mc[0]});
    end_sim;
  end
endmodule // tb_lbk_ctrl
